/* logic/occ_pkg.sv */
// package: shared types, widths and timing constants for the operator console
`default_nettype none
package occ_pkg;
	localparam int ADDR_W       = 15;
	localparam int DATA_W       = 18;
	localparam int SEL_POS      = 12;
	localparam int SEL_W        = 4;
	localparam int KEY_N        = 10;
	localparam int CLK_HZ       = 100_000_000;
	localparam int REP_MIN_HZ   = 1;
	localparam int REP_RUN_HZ   = 10_000;
	localparam int REP_MEM_HZ   = 3_000;
	// shortest repeat period rounds up, longest rounds down
	localparam int REP_RUN_CYC  = (CLK_HZ + REP_RUN_HZ - 1) / REP_RUN_HZ;
	localparam int REP_MEM_CYC  = (CLK_HZ + REP_MEM_HZ - 1) / REP_MEM_HZ;
	localparam int REP_SLOW_CYC = CLK_HZ / REP_MIN_HZ;
	localparam int REP_CNT_W    = 27;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;

	typedef enum logic [1:0] {STEP_NONE, STEP_TIME, STEP_MAJOR, STEP_INST} occ_step_t;
	typedef enum logic [2:0] {FN_NONE, FN_START, FN_CONT, FN_EXECUTE_SWITCH_WORD_KEY, FN_DEP_THIS, FN_DEP_NEXT,
		FN_EXAM_THIS, FN_EXAM_NEXT} occ_fn_t;

	typedef struct packed {
		logic start;
		logic cont;
		logic stop;
		logic execute_switch_word_key;
		logic dep_this;
		logic dep_next;
		logic exam_this;
		logic exam_next;
		logic reset;
		logic tape_load;
	} occ_keys_t;

	typedef struct packed {
		logic      user_mode;
		logic      bank_mode;
		logic      clk_inhibit;
		occ_step_t step;
	} occ_mode_t;

	typedef struct packed {
		logic start;
		logic cont;
		logic execute_switch_word_key;
		logic reset;
		logic tape_load;
	} occ_cmd_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} occ_mem_req_t;
endpackage
`default_nettype wire

/* logic/occ_key_edge.sv */
// key synchroniser and press detector, one lane per key
`timescale 1ns/10ps
`default_nettype none
module occ_key_edge #(
	parameter int N = 10
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic [N-1:0] key_i,
	output logic      [N-1:0] level_o,
	output logic      [N-1:0] rise_o
);
	logic [N-1:0] s1_q, s2_q, s3_q;
	logic [N-1:0] s1_d, s2_d, s3_d;

	always_comb begin
		s1_d = key_i;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign level_o = s2_q;
	assign rise_o  = s2_q & ~s3_q;
endmodule // occ_key_edge
`default_nettype wire

/* logic/occ_console.sv */
// operator console control: keys to processor commands, deposit/examine, repeat, display
`timescale 1ns/10ps
`default_nettype none
module occ_console
	import occ_pkg::*;
#(
	parameter int unsigned REP_RUN_CYCLES  = REP_RUN_CYC,
	parameter int unsigned REP_MEM_CYCLES  = REP_MEM_CYC,
	parameter int unsigned REP_SLOW_CYCLES = REP_SLOW_CYC
) (
	input  wire logic                                 mclk_i,
	input  wire logic                                 reset_n_i,
	input  wire occ_pkg::occ_keys_t                   keys_i,
	input  wire logic [occ_pkg::ADDR_W-1:0]           address_sw_i,
	input  wire logic [occ_pkg::DATA_W-1:0]           data_sw_i,
	input  wire logic                                 step_per_time_state_i,
	input  wire logic                                 step_per_major_state_i,
	input  wire logic                                 step_per_instruction_i,
	input  wire logic                                 auto_repeat_select_i,
	input  wire logic [occ_pkg::REP_CNT_W-1:0]        repeat_period_i,
	input  wire logic                                 user_sel_i,
	input  wire logic                                 bank_sel_i,
	input  wire logic                                 clock_inhibit_sel_i,
	input  wire logic                                 reg_group_rear_i,
	input  wire logic [occ_pkg::SEL_W-1:0]            reg_select_i,
	input  wire logic [occ_pkg::SEL_POS-1:0][occ_pkg::DATA_W-1:0] front_regs_i,
	input  wire logic [occ_pkg::SEL_POS-1:0][occ_pkg::DATA_W-1:0] rear_regs_i,
	input  wire logic                                 cpu_running_i,
	input  wire logic                                 mem_ack_i,
	input  wire logic [occ_pkg::DATA_W-1:0]           mem_rdata_i,
	output occ_pkg::occ_cmd_t                         cpu_cmd_o,
	output occ_pkg::occ_mode_t                        cpu_mode_o,
	output logic [occ_pkg::ADDR_W-1:0]                cpu_start_addr_o,
	output logic [occ_pkg::DATA_W-1:0]                execute_switch_word_key_word_o,
	output logic                                      stop_req_o,
	output occ_pkg::occ_mem_req_t                     mem_o,
	output logic                                      mb_load_o,
	output logic [occ_pkg::DATA_W-1:0]                mb_data_o,
	output logic [occ_pkg::DATA_W-1:0]                register_lamps_o
);
	import occ_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_RUN} occ_state_t;

	occ_keys_t             lvl, rise;
	occ_state_t            state_q, state_d;
	occ_fn_t               fn_q, fn_d, issue;
	occ_cmd_t              cmd_q, cmd_d;
	occ_mode_t             mode_q, mode_d;
	occ_mem_req_t          mem_q, mem_d;
	logic [ADDR_W-1:0]     start_addr_q, start_addr_d;
	logic [ADDR_W-1:0]     next_off_q, next_off_d;
	logic [DATA_W-1:0]     execute_switch_word_key_q, execute_switch_word_key_d;
	logic [DATA_W-1:0]     mb_q, mb_d;
	logic [DATA_W-1:0]     lamps_q, lamps_d;
	logic [REP_CNT_W-1:0]  rep_cnt_q, rep_cnt_d, period;
	logic                  stop_q, stop_d;
	logic                  mb_load_q, mb_load_d;
	logic                  seen_q, seen_d;
	logic                  tick;

	occ_key_edge #(
		.N (KEY_N)
	) u_keys (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.key_i     (keys_i),
		.level_o   (lvl),
		.rise_o    (rise)
	);

	// repeat period clamped to the allowed rate range of the function in hand
	always_comb begin
		period = repeat_period_i;
		if (fn_q == FN_CONT || fn_q == FN_EXECUTE_SWITCH_WORD_KEY) begin
			if (period < REP_CNT_W'(REP_RUN_CYCLES))
				period = REP_CNT_W'(REP_RUN_CYCLES);
		end else if (period < REP_CNT_W'(REP_MEM_CYCLES)) begin
			period = REP_CNT_W'(REP_MEM_CYCLES);
		end
		if (period > REP_CNT_W'(REP_SLOW_CYCLES))
			period = REP_CNT_W'(REP_SLOW_CYCLES);
	end

	assign tick = (rep_cnt_q >= period - REP_CNT_W'(1));

	always_comb begin
		state_d      = state_q;
		fn_d         = fn_q;
		cmd_d        = '0;
		mode_d       = mode_q;
		mem_d        = mem_q;
		start_addr_d = start_addr_q;
		next_off_d   = next_off_q;
		execute_switch_word_key_d       = execute_switch_word_key_q;
		mb_d         = mb_q;
		mb_load_d    = 1'b0;
		stop_d       = stop_q;
		seen_d       = seen_q;
		rep_cnt_d    = rep_cnt_q;
		issue        = FN_NONE;

		// selectors that the processor follows live
		mode_d.clk_inhibit = clock_inhibit_sel_i;
		if (step_per_time_state_i)
			mode_d.step = STEP_TIME;
		else if (step_per_major_state_i)
			mode_d.step = STEP_MAJOR;
		else if (step_per_instruction_i)
			mode_d.step = STEP_INST;
		else
			mode_d.step = STEP_NONE;

		// halt request held until the core reports it has stopped
		if (rise.stop) begin
			stop_d = 1'b1;
			fn_d   = FN_NONE;
		end else if (!cpu_running_i) begin
			stop_d = 1'b0;
		end
		if (!auto_repeat_select_i)
			fn_d = FN_NONE;

		// repeat divider counts only while halted with a function armed
		if (state_q == ST_IDLE && fn_d != FN_NONE && !cpu_running_i) begin
			rep_cnt_d = tick ? '0 : rep_cnt_q + REP_CNT_W'(1);
		end else begin
			rep_cnt_d = '0;
		end

		unique case (state_q)
			ST_IDLE: begin
				if (lvl.reset && lvl.stop && (rise.reset || rise.stop)) begin
					cmd_d.reset = 1'b1;
					fn_d        = FN_NONE;
				end else if (cpu_running_i) begin
					issue = FN_NONE;
				end else if (rise.reset) begin
					cmd_d.reset = 1'b1;
					fn_d        = FN_NONE;
				end else if (rise.start) begin
					issue = FN_START;
				end else if (rise.cont) begin
					issue = FN_CONT;
				end else if (rise.execute_switch_word_key) begin
					issue = FN_EXECUTE_SWITCH_WORD_KEY;
				end else if (rise.dep_this) begin
					issue = FN_DEP_THIS;
				end else if (rise.dep_next) begin
					issue = FN_DEP_NEXT;
				end else if (rise.exam_this) begin
					issue = FN_EXAM_THIS;
				end else if (rise.exam_next) begin
					issue = FN_EXAM_NEXT;
				end else if (rise.tape_load) begin
					cmd_d.tape_load = 1'b1;
					start_addr_d    = address_sw_i;
					fn_d            = FN_NONE;
					seen_d          = 1'b0;
					state_d         = ST_RUN;
				end else if (fn_q != FN_NONE && tick && auto_repeat_select_i && !rise.stop) begin
					issue = fn_q;
				end

				if (issue != FN_NONE)
					fn_d = auto_repeat_select_i ? issue : FN_NONE;

				unique case (issue)
					FN_START: begin
						cmd_d.start         = 1'b1;
						start_addr_d        = address_sw_i;
						mode_d.user_mode    = user_sel_i;
						mode_d.bank_mode    = bank_sel_i;
						seen_d              = 1'b0;
						state_d             = ST_RUN;
					end
					FN_CONT: begin
						cmd_d.cont = 1'b1;
						seen_d     = 1'b0;
						state_d    = ST_RUN;
					end
					FN_EXECUTE_SWITCH_WORD_KEY: begin
						cmd_d.execute_switch_word_key = 1'b1;
						execute_switch_word_key_d     = data_sw_i;
						seen_d     = 1'b0;
						state_d    = ST_RUN;
					end
					FN_DEP_THIS, FN_DEP_NEXT, FN_EXAM_THIS, FN_EXAM_NEXT: begin
						// memory port only, no working register is touched
						mem_d.req   = 1'b1;
						mem_d.we    = (issue == FN_DEP_THIS || issue == FN_DEP_NEXT);
						mem_d.wdata = data_sw_i;
						if (issue == FN_DEP_NEXT || issue == FN_EXAM_NEXT) begin
							next_off_d = next_off_q + ADDR_W'(1);
							mem_d.addr = address_sw_i + next_off_q + ADDR_W'(1);
						end else begin
							next_off_d = ADDR_ZERO;
							mem_d.addr = address_sw_i;
						end
						state_d = ST_MEM;
					end
					default: begin
						state_d = state_d;
					end
				endcase
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					mem_d.req = 1'b0;
					if (!mem_q.we) begin
						mb_d      = mem_rdata_i;
						mb_load_d = 1'b1;
					end
					state_d = ST_IDLE;
				end
			end
			ST_RUN: begin
				if (lvl.reset && lvl.stop && (rise.reset || rise.stop)) begin
					// unconditional reset while running
					cmd_d.reset = 1'b1;
					fn_d        = FN_NONE;
					state_d     = ST_IDLE;
				end else if (cpu_running_i)
					seen_d = 1'b1;
				else if (seen_q)
					state_d = ST_IDLE;
			end
		endcase

		// display multiplexer
		if (reg_select_i < SEL_W'(SEL_POS))
			lamps_d = reg_group_rear_i ? rear_regs_i[reg_select_i] : front_regs_i[reg_select_i];
		else
			lamps_d = DATA_ZERO;
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state_q      <= ST_IDLE;
			fn_q         <= FN_NONE;
			cmd_q        <= '0;
			mode_q       <= '0;
			mem_q        <= '0;
			start_addr_q <= ADDR_ZERO;
			next_off_q   <= ADDR_ZERO;
			execute_switch_word_key_q       <= DATA_ZERO;
			mb_q         <= DATA_ZERO;
			mb_load_q    <= 1'b0;
			lamps_q      <= DATA_ZERO;
			rep_cnt_q    <= '0;
			stop_q       <= 1'b0;
			seen_q       <= 1'b0;
		end else begin
			state_q      <= state_d;
			fn_q         <= fn_d;
			cmd_q        <= cmd_d;
			mode_q       <= mode_d;
			mem_q        <= mem_d;
			start_addr_q <= start_addr_d;
			next_off_q   <= next_off_d;
			execute_switch_word_key_q       <= execute_switch_word_key_d;
			mb_q         <= mb_d;
			mb_load_q    <= mb_load_d;
			lamps_q      <= lamps_d;
			rep_cnt_q    <= rep_cnt_d;
			stop_q       <= stop_d;
			seen_q       <= seen_d;
		end
	end

	assign cpu_cmd_o        = cmd_q;
	assign cpu_mode_o       = mode_q;
	assign cpu_start_addr_o = start_addr_q;
	assign execute_switch_word_key_word_o      = execute_switch_word_key_q;
	assign stop_req_o       = stop_q;
	assign mem_o            = mem_q;
	assign mb_load_o        = mb_load_q;
	assign mb_data_o        = mb_q;
	assign register_lamps_o = lamps_q;
endmodule // occ_console
`default_nettype wire

/* sim/occ_core_model.sv */
// processor core and memory stand-in
`timescale 1ns/10ps
`default_nettype none
module occ_core_model (
	input  wire logic                  mclk_i,
	input  wire logic                  reset_n_i,
	input  wire occ_pkg::occ_cmd_t     cmd_i,
	input  wire occ_pkg::occ_mem_req_t mem_i,
	output logic                       running_o,
	output logic                       ack_o,
	output logic [occ_pkg::DATA_W-1:0] rdata_o
);
	import occ_pkg::*;
	logic [DATA_W-1:0] mem_q [32];
	logic [4:0]        run_q;
	logic [1:0]        wait_q;
	assign running_o = (run_q != 5'h00);
	always @(posedge mclk_i) begin
		rdata_o <= ~rdata_o;
		ack_o <= 1'b0;
		if (!reset_n_i) begin
			run_q <= 5'h00;
			wait_q <= 2'h0;
			for (int i = 0; i < 32; i++)
				mem_q[i] <= DATA_ZERO;
		end else begin
			// one instruction (or a tape load) runs, then the core halts
			if (cmd_i.start || cmd_i.cont || cmd_i.execute_switch_word_key || cmd_i.tape_load)
				run_q <= 5'h10;
			else if (run_q != 5'h00)
				run_q <= run_q - 5'h01;
			if (mem_i.req && !ack_o) begin
				wait_q <= wait_q + 2'h1;
				if (wait_q == 2'h2) begin
					wait_q <= 2'h0;
					ack_o <= 1'b1;
					rdata_o <= mem_q[mem_i.addr[4:0]];
					if (mem_i.we)
						mem_q[mem_i.addr[4:0]] <= mem_i.wdata;
				end
			end
		end
	end
endmodule // occ_core_model
`default_nettype wire

/* sim/occ_console_checker.sv */
// concurrent checks on the console ports
`timescale 1ns/10ps
`default_nettype none
module occ_console_checker (
	input wire logic                                          mclk_i,
	input wire logic                                          reset_n_i,
	input wire logic [occ_pkg::ADDR_W-1:0]                    address_sw_i,
	input wire logic [occ_pkg::DATA_W-1:0]                    data_sw_i,
	input wire logic                                          user_sel_i,
	input wire logic                                          bank_sel_i,
	input wire logic                                          clock_inhibit_sel_i,
	input wire logic                                          reg_group_rear_i,
	input wire logic [occ_pkg::SEL_W-1:0]                     reg_select_i,
	input wire logic [occ_pkg::SEL_POS-1:0][occ_pkg::DATA_W-1:0] front_regs_i,
	input wire logic [occ_pkg::SEL_POS-1:0][occ_pkg::DATA_W-1:0] rear_regs_i,
	input wire logic                                          cpu_running_i,
	input wire logic                                          mem_ack_i,
	input wire logic [occ_pkg::DATA_W-1:0]                    mem_rdata_i,
	input wire occ_pkg::occ_cmd_t                             cpu_cmd_o,
	input wire occ_pkg::occ_mode_t                            cpu_mode_o,
	input wire logic [occ_pkg::ADDR_W-1:0]                    cpu_start_addr_o,
	input wire logic [occ_pkg::DATA_W-1:0]                    execute_switch_word_key_word_o,
	input wire logic                                          stop_req_o,
	input wire occ_pkg::occ_mem_req_t                         mem_o,
	input wire logic                                          mb_load_o,
	input wire logic [occ_pkg::DATA_W-1:0]                    mb_data_o,
	input wire logic [occ_pkg::DATA_W-1:0]                    register_lamps_o
);
	import occ_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	logic [DATA_W-1:0] lamp_w;
	assign lamp_w = (reg_select_i < 4'hC) ?
		(reg_group_rear_i ? rear_regs_i[reg_select_i] : front_regs_i[reg_select_i]) : DATA_ZERO;
	sequence s_rd_ack; mem_o.req && !mem_o.we && mem_ack_i; endsequence
	sequence s_mb_up; mb_load_o && mb_data_o == $past(mem_rdata_i); endsequence
	property p_rd_load; s_rd_ack |=> s_mb_up; endproperty
	property p_start; cpu_cmd_o.start |-> cpu_start_addr_o == address_sw_i &&
		cpu_mode_o.user_mode == user_sel_i && cpu_mode_o.bank_mode == bank_sel_i; endproperty
	property p_pulse; (|cpu_cmd_o) |=> !(|cpu_cmd_o); endproperty
	property p_busy; (cpu_cmd_o.start || cpu_cmd_o.cont || cpu_cmd_o.execute_switch_word_key) |-> !$past(cpu_running_i); endproperty
	property p_hold; mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr); endproperty
	property p_drop; mem_o.req && mem_ack_i |=> !mem_o.req; endproperty
	property p_wdata; mem_o.req && mem_o.we |-> mem_o.wdata == data_sw_i; endproperty
	property p_execute_switch_word_key; cpu_cmd_o.execute_switch_word_key |-> execute_switch_word_key_word_o == data_sw_i; endproperty
	property p_lamp; $past(reset_n_i) |-> register_lamps_o == $past(lamp_w); endproperty
	property p_clk_inh; $past(reset_n_i) |-> cpu_mode_o.clk_inhibit == $past(clock_inhibit_sel_i); endproperty
	property p_stop; stop_req_o && !cpu_running_i |=> !stop_req_o; endproperty
	a_rd_load: assert property (p_rd_load) else $error("examined word not loaded");
	a_start: assert property (p_start) else $error("start address or mode wrong");
	a_pulse: assert property (p_pulse) else $error("command pulse too long");
	a_busy: assert property (p_busy) else $error("command while running");
	a_hold: assert property (p_hold) else $error("memory request not held");
	a_drop: assert property (p_drop) else $error("memory request not dropped");
	a_wdata: assert property (p_wdata) else $error("deposit data wrong");
	a_execute_switch_word_key: assert property (p_execute_switch_word_key) else $error("execute word wrong");
	a_lamp: assert property (p_lamp) else $error("lamp source wrong");
	a_clk_inh: assert property (p_clk_inh) else $error("clock inhibit wrong");
	a_stop: assert property (p_stop) else $error("stop request stuck");
endmodule // occ_console_checker
bind occ_console occ_console_checker u_chk (.*);
`default_nettype wire

/* sim/occ_console_tb.sv */
// self-checking bench for the operator console
`timescale 1ns/10ps
`default_nettype none
module occ_console_tb;
	import occ_pkg::*;
	logic mclk_i = 1'b0, reset_n_i = 1'b0, rep = 1'b0, usr = 1'b0, bnk = 1'b0, cin = 1'b0, grp = 1'b0;
	logic stt = 1'b0, stm = 1'b0, sti = 1'b0, run, ack, stop_req, mbl;
	occ_keys_t keys = '0, rk;
	logic [ADDR_W-1:0] asw = 15'h0010, sa;
	logic [DATA_W-1:0] dsw = 18'h00000, rdata, exw, mbd, lamps;
	logic [REP_CNT_W-1:0] per = 27'h0000014;
	logic [SEL_W-1:0] sel = 4'h0;
	logic [SEL_POS-1:0][DATA_W-1:0] fr, rr;
	occ_cmd_t cmd;
	occ_mode_t mode;
	occ_mem_req_t mreq;
	int cnt [6] = '{default: 0};
	int miscompares = 0, checks_done = 0, c, ci;
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) for (int i = 0; i < 6; i++) if ((i < 5 ? cmd[i] : mbl) === 1'b1) cnt[i]++;
	occ_console #(.REP_RUN_CYCLES(8), .REP_MEM_CYCLES(12), .REP_SLOW_CYCLES(64)) dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .keys_i(keys), .address_sw_i(asw), .data_sw_i(dsw),
		.step_per_time_state_i(stt), .step_per_major_state_i(stm), .step_per_instruction_i(sti),
		.auto_repeat_select_i(rep), .repeat_period_i(per), .user_sel_i(usr), .bank_sel_i(bnk),
		.clock_inhibit_sel_i(cin), .reg_group_rear_i(grp), .reg_select_i(sel), .front_regs_i(fr),
		.rear_regs_i(rr), .cpu_running_i(run), .mem_ack_i(ack), .mem_rdata_i(rdata), .cpu_cmd_o(cmd),
		.cpu_mode_o(mode), .cpu_start_addr_o(sa), .execute_switch_word_key_word_o(exw), .stop_req_o(stop_req), .mem_o(mreq),
		.mb_load_o(mbl), .mb_data_o(mbd), .register_lamps_o(lamps));
	occ_core_model u_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_i(cmd), .mem_i(mreq),
		.running_o(run), .ack_o(ack), .rdata_o(rdata));
	task automatic tick(input int n); repeat (n) @(negedge mclk_i); endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic press(input occ_keys_t k); keys = k; tick(4); keys = '0; tick(6); endtask
	task automatic mem_op(input occ_keys_t k);
		int n;
		keys = k;
		tick(4);
		keys = '0;
		for (n = 0; n < 50 && mreq.req === 1'b1; n++) tick(1);
		if (n == 50) begin
			miscompares++;
			print_verdict();
		end
		tick(2);
	endtask
	initial begin
		for (int i = 0; i < SEL_POS; i++) begin
			fr[i] = 18'h01000 + 18'(i);
			rr[i] = 18'h32000 + 18'(i);
		end
		tick(20);
		reset_n_i = 1'b1;
		tick(3);
		usr = 1'b1;
		bnk = 1'b1;
		press(10'h200);
		chk("start", 18'h00001, 18'(cnt[4]));
		chk("start addr", 18'(asw), 18'(sa));
		chk("user bank", 18'h00003, {16'h0000, mode.user_mode, mode.bank_mode});
		press(10'h100);
		chk("cont ignored", 18'h00000, 18'(cnt[3]));
		press(10'h080);
		tick(20);
		press(10'h200);
		press(10'h082);
		chk("reset stop", 18'h00001, 18'(cnt[1]));
		tick(20);
		dsw = 18'h2A5A5;
		press(10'h040);
		chk("execute_switch_word_key", 18'h00001, 18'(cnt[2]));
		chk("execute_switch_word_key word", dsw, exw);
		tick(20);
		asw = 15'h0044;
		press(10'h001);
		chk("tape load", 18'h00001, 18'(cnt[0]));
		chk("load addr", 18'(asw), 18'(sa));
		tick(20);
		asw = 15'h0100;
		for (int i = 0; i < 3; i++) begin
			dsw = 18'h15550 + 18'(i);
			mem_op(i == 0 ? 10'h020 : 10'h010);
		end
		for (int i = 0; i < 3; i++) begin
			mem_op(i == 0 ? 10'h008 : 10'h004);
			chk("mb", 18'h15550 + 18'(i), mbd);
		end
		chk("pc kept", 18'h00044, 18'(sa));
		for (int w = 0; w < 2; w++) begin
			c = cnt[3];
			rep = 1'b1;
			press(10'h100);
			tick(150);
			chk("repeat", 18'h00001, 18'((cnt[3] - c) >= 3));
			if (w == 1) press(10'h080);
			else rep = 1'b0;
			tick(60);
			rep = 1'b0;
			c = cnt[3];
			tick(200);
			chk("repeat end", 18'(c), 18'(cnt[3]));
		end
		per = 27'h0000004;
		mem_op(10'h008);
		chk("mb this", 18'h15550, mbd);
		for (int f = 0; f < 3; f++) begin
			rk = f == 0 ? 10'h040 : f == 1 ? 10'h200 : 10'h004;
			ci = f == 0 ? 2 : f == 1 ? 4 : 5;
			c = cnt[ci];
			rep = 1'b1;
			press(rk);
			tick(190);
			press(10'h080);
			rep = 1'b0;
			tick(40);
			chk("repeat rate", 18'h00001, 18'(cnt[ci] - c >= 2 && cnt[ci] - c <= 210 / (f == 0 ? 8 : 12) + 1));
		end
		chk("next addr", 18'h00100 + 18'(cnt[5] - c), 18'(mreq.addr));
		press(10'h200);
		keys = 10'h080;
		tick(4);
		keys = '0;
		chk("stop held", 18'h00001, 18'(stop_req));
		tick(20);
		chk("stop done", 18'h00000, 18'(stop_req));
		for (int i = 0; i < 3; i++) begin
			{stt, stm, sti} = 3'h4 >> i;
			cin = ~cin;
			tick(2);
			chk("step", 18'(i + 1), 18'(mode.step));
			chk("clk inhibit", 18'(cin), 18'(mode.clk_inhibit));
		end
		for (int g = 0; g < 2; g++) for (int s = 0; s < 14; s++) begin
			grp = g[0];
			sel = s[3:0];
			tick(2);
			chk("lamps", s < 12 ? (g == 1 ? rr[s] : fr[s]) : DATA_ZERO, lamps);
		end
		print_verdict();
	end
endmodule // occ_console_tb
`default_nettype wire
